// ---- hdl/tx_input_fault.v ----
// Dual transmit character input capture and fault flag, with an APB
// register file and one level interrupt.
// Assumes the pins are asynchronous to sys_clk and sampled by it.
//
// What this block does
// - Host presents 10-bit characters for capture.
// - Latch chooses the transmit interface clock.
// - Buffer underflow or overflow raises fault flag.
// - Fault stays high until buffer re-centered.
// - Self-test enable at zero shows test progress.
// - One character-period pulse per 511-character pass.
// - Both drivers off powers PLL down, flag high.
// - Missing reference clock holds fault flag high.
// - Flag follows ref, host clock and re-center events; forcing acts on next sys_clk edge.
// - Select zero uses host clock, else reference.
// - Writing recenter as zero initialises buffer phase.
// - Half-rate reference samples on both edges.
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "tx_input_fault_defs.vh"

module tx_input_fault #(
  parameter NCH      = 2,               // Transmit channels.
  parameter DEPTH    = `BUF_DEPTH,      // Phase-align buffer depth.
  parameter LOSS_CYC = `REF_LOSS_CYC    // Cycles without ref edge.
) (
  input  wire                 sys_clk,         // System clock, 20 MHz.
  input  wire                 rst_b,           // Async reset, active low.
  input  wire                 psel,            // APB select.
  input  wire                 penable,         // APB enable.
  input  wire                 pwrite,          // APB direction.
  input  wire [11:0]          paddr,           // APB byte address.
  input  wire [31:0]          pwdata,          // APB write data.
  output reg                  pready,          // APB ready.
  output reg  [31:0]          prdata,          // APB read data.
  output reg                  pslverr,         // APB error, unmapped or wrong direction.
  output reg                  irq,             // Level interrupt.
  input  wire [`CHAR_W-1:0]   tx_char_in_a,    // Channel A characters.
  input  wire [`CHAR_W-1:0]   tx_char_in_b,    // Channel B characters.
  input  wire                 tx_if_clk_in_a,  // Channel A host clock.
  input  wire                 tx_if_clk_in_b,  // Channel B host clock.
  input  wire                 ref_clk_in_a,    // Channel A ref clock.
  input  wire                 ref_clk_in_b,    // Channel B ref clock.
  output wire                 tx_fault_flag_a, // Channel A fault flag.
  output wire                 tx_fault_flag_b, // Channel B fault flag.
  output wire [`CHAR_W-1:0]   tx_char_out_a,   // Channel A captured.
  output wire [`CHAR_W-1:0]   tx_char_out_b,   // Channel B captured.
  output wire                 tx_char_vld_a,   // Channel A capture pulse.
  output wire                 tx_char_vld_b    // Channel B capture pulse.
);

  // Constants are cut to the width of the counters they meet, so a
  // comparison never mixes a 32-bit value with a narrow register.
  localparam integer      BIST_LAST  = `BIST_LEN - 1;
  localparam [`LVL_W-1:0] LVL_ONE    = {{(`LVL_W-1){1'b0}}, 1'b1};
  localparam [`LVL_W-1:0] LVL_FULL   = DEPTH[`LVL_W-1:0];
  localparam [`LVL_W-1:0] LVL_CENTER = DEPTH[`LVL_W:1];
  localparam [`CNT_W-1:0] CNT_ONE    = {{(`CNT_W-1){1'b0}}, 1'b1};
  localparam [`CNT_W-1:0] CNT_LAST   = BIST_LAST[`CNT_W-1:0];
  localparam [11:0]       LOSS_ONE   = 12'h001;
  localparam [11:0]       LOSS_MAX   = LOSS_CYC[11:0];
  localparam              SW         = `CHAR_W + 2;

  // ***************************************************************
  // Register file state
  // ***************************************************************
  reg  [31:0]          ctrl_q;
  reg  [`IRQ_W-1:0]    irq_stat_q;
  reg  [`IRQ_W-1:0]    irq_en_q;
  wire [`IRQ_W-1:0]    irq_ev;
  wire [NCH-1:0]       recenter;
  wire [NCH-1:0]       fault;
  wire [NCH-1:0]       ref_ok;
  wire [NCH-1:0]       pll_dn;
  wire [NCH*`LVL_W-1:0]  lvl_bus;
  wire [NCH*`CHAR_W-1:0] char_bus;
  wire [NCH-1:0]       vld_bus;

  wire [NCH*`CHAR_W-1:0] pin_char = {tx_char_in_b, tx_char_in_a};
  wire [NCH-1:0]         pin_ifc  = {tx_if_clk_in_b, tx_if_clk_in_a};
  wire [NCH-1:0]         pin_ref  = {ref_clk_in_b, ref_clk_in_a};

  // A write lands only at the edge where pready is seen high.
  wire acc     = psel & penable;
  wire wr_take = acc & pready & pwrite;
  wire wr_ctrl = wr_take & (paddr == `OFS_CTRL);
  wire wr_clr  = wr_take & (paddr == `OFS_IRQ_CLR);
  wire wr_en   = wr_take & (paddr == `OFS_IRQ_EN);

  // ***************************************************************
  // Per-channel capture, buffer, self-test and fault logic
  // ***************************************************************
  genvar n;
  generate
    for (n = 0; n < NCH; n = n + 1) begin : g_ch
      wire [SW-1:0]     s_now;
      wire [SW-1:0]     s_old;
      reg  [`CHAR_W-1:0] char_q;
      reg               vld_q;
      reg  [`LVL_W-1:0] lvl_q;
      reg               buf_err_q;
      reg  [`CNT_W-1:0] cnt_q;
      reg               pass_q;
      reg  [11:0]       idle_q;
      reg               absent_q;
      reg               fault_q;
      wire              sel_ref;
      wire              st_off;
      wire              half;
      wire              if_rise;
      wire              ref_rise;
      wire              ref_fall;
      wire              char_ev;
      wire              cap_ev;
      wire              wr_ev;
      wire              ovf;
      wire              unf;
      wire              pwr_dn;

      edge_sync #(
        .WIDTH (SW)
      ) u_sync (
        .sys_clk  (sys_clk),
        .rst_b    (rst_b),
        .pin_in   ({pin_char[n*`CHAR_W +: `CHAR_W], pin_ifc[n], pin_ref[n]}),
        .sync_out (s_now),
        .prev_out (s_old)
      );

      assign sel_ref  = ctrl_q[n*`CH_STRIDE + `CTRL_SEL_BIT];
      assign st_off   = ~ctrl_q[n*`CH_STRIDE + `CTRL_BIST_BIT];
      assign half     = ctrl_q[n*`CH_STRIDE + `CTRL_HALF_BIT];
      assign pwr_dn   = ~ctrl_q[n*`CH_STRIDE + `CTRL_DRV1_BIT] &
                        ~ctrl_q[n*`CH_STRIDE + `CTRL_DRV2_BIT];
      // The synchroniser resets to zero, the idle level of every clock
      // pin, so the release of reset never shows a false edge.
      assign if_rise  = s_now[1] & ~s_old[1];
      assign ref_rise = s_now[0] & ~s_old[0];
      assign ref_fall = ~s_now[0] & s_old[0];
      // Half-rate reference carries a character on each edge.
      assign char_ev  = ref_rise | (half & ref_fall);
      // Select zero takes the host clock, otherwise the reference.
      assign cap_ev   = sel_ref ? char_ev : if_rise;
      assign wr_ev    = ~sel_ref & if_rise;
      assign ovf = wr_ev & ~char_ev & (lvl_q == LVL_FULL);
      assign unf = ~wr_ev & char_ev & ~sel_ref & (lvl_q == {`LVL_W{1'b0}});

      // The data stage one cycle older than the edge is sampled, so
      // a host changing data just after its clock edge is not caught.
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          char_q <= {`CHAR_W{1'b0}};
          vld_q  <= 1'b0;
        end else begin
          vld_q <= cap_ev;
          if (cap_ev) begin
            char_q <= s_old[SW-1:2];
          end
        end
      end

      // Occupancy model of the phase-align buffer: host clock fills,
      // character clock drains. It idles at center on the ref clock.
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          lvl_q     <= LVL_CENTER;
          buf_err_q <= 1'b0;
        end else begin
          if (recenter[n] || sel_ref) begin
            lvl_q <= LVL_CENTER;
          end else if (wr_ev && !char_ev && !ovf) begin
            lvl_q <= lvl_q + LVL_ONE;
          end else if (char_ev && !wr_ev && !unf) begin
            lvl_q <= lvl_q - LVL_ONE;
          end
          // A fresh error beats a re-center in the same cycle.
          if (ovf || unf) begin
            buf_err_q <= 1'b1;
          end else if (recenter[n]) begin
            buf_err_q <= 1'b0;
          end
        end
      end

      // Self-test pass counter, one step per character clock.
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          cnt_q  <= {`CNT_W{1'b0}};
          pass_q <= 1'b0;
        end else if (!st_off) begin
          cnt_q  <= {`CNT_W{1'b0}};
          pass_q <= 1'b0;
        end else if (char_ev) begin
          pass_q <= (cnt_q == CNT_LAST);
          cnt_q  <= (cnt_q == CNT_LAST) ? {`CNT_W{1'b0}} : cnt_q + CNT_ONE;
        end
      end

      // Reference watchdog: no edge for LOSS_CYC cycles means absent.
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          idle_q   <= {12{1'b0}};
          absent_q <= 1'b1;
        end else if (ref_rise || ref_fall) begin
          idle_q   <= {12{1'b0}};
          absent_q <= 1'b0;
        end else if (idle_q >= LOSS_MAX) begin
          absent_q <= 1'b1;
        end else begin
          idle_q <= idle_q + LOSS_ONE;
        end
      end

      // Forcing terms act on the next sys_clk edge regardless of the
      // reference; the status terms move with reference, host clock and re-center events.
      always @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          fault_q <= 1'b1;
        end else if (pwr_dn || absent_q) begin
          fault_q <= 1'b1;
        end else if (st_off) begin
          fault_q <= pass_q;
        end else begin
          fault_q <= buf_err_q;
        end
      end

      assign fault[n]  = fault_q;
      assign ref_ok[n] = ~absent_q;
      assign pll_dn[n] = pwr_dn;
      assign vld_bus[n] = vld_q;
      assign lvl_bus[n*`LVL_W +: `LVL_W]   = lvl_q;
      assign char_bus[n*`CHAR_W +: `CHAR_W] = char_q;
      assign irq_ev[n*`IRQ_STRIDE + `IRQ_BUF_BIT]  = ovf | unf;
      assign irq_ev[n*`IRQ_STRIDE + `IRQ_PASS_BIT] = char_ev & st_off &
                                                     (cnt_q == CNT_LAST);
      assign irq_ev[n*`IRQ_STRIDE + `IRQ_LOSS_BIT] = ~absent_q &
        ~(ref_rise | ref_fall) & (idle_q >= LOSS_MAX);
      // Re-center fires when software writes the latch bit as zero.
      assign recenter[n] = wr_ctrl &
        ~pwdata[n*`CH_STRIDE + `CTRL_RCTR_BIT];
    end
  endgenerate

  assign tx_fault_flag_a = fault[0];
  assign tx_fault_flag_b = fault[1];
  assign tx_char_out_a   = char_bus[0 +: `CHAR_W];
  assign tx_char_out_b   = char_bus[`CHAR_W +: `CHAR_W];
  assign tx_char_vld_a   = vld_bus[0];
  assign tx_char_vld_b   = vld_bus[1];

  // ***************************************************************
  // Status word assembly
  // ***************************************************************
  reg [31:0] status_w;
  reg [31:0] char_w;
  integer k;
  always @* begin
    status_w = 32'h0000_0000;
    char_w   = 32'h0000_0000;
    for (k = 0; k < NCH; k = k + 1) begin
      status_w[k*`CH_STRIDE + `ST_FAULT_BIT] = fault[k];
      status_w[k*`CH_STRIDE + `ST_REF_BIT]   = ref_ok[k];
      status_w[k*`CH_STRIDE + `ST_PLL_BIT]   = pll_dn[k];
      status_w[k*`CH_STRIDE + `ST_LVL_LSB +: `LVL_W] =
        lvl_bus[k*`LVL_W +: `LVL_W];
    end
    char_w[`CHAR_W-1:0] = char_bus[0 +: `CHAR_W];
    char_w[`CHAR_B_LSB +: `CHAR_W] = char_bus[`CHAR_W +: `CHAR_W];
  end

  // ***************************************************************
  // APB slave: one wait state, registered answer
  // ***************************************************************
  // A refused write answers with an error and leaves all state alone.
  reg [31:0] rdata_d;
  reg        err_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d   = 1'b0;
    if (paddr == `OFS_CTRL) begin
      rdata_d = ctrl_q;
    end else if (paddr == `OFS_STATUS) begin
      rdata_d = status_w;
      err_d   = pwrite;
    end else if (paddr == `OFS_CHAR) begin
      rdata_d = char_w;
      err_d   = pwrite;
    end else if (paddr == `OFS_IRQ_STAT) begin
      rdata_d = {{(32-`IRQ_W){1'b0}}, irq_stat_q};
      err_d   = pwrite;
    end else if (paddr == `OFS_IRQ_CLR) begin
      err_d   = ~pwrite;
    end else if (paddr == `OFS_IRQ_EN) begin
      rdata_d = {{(32-`IRQ_W){1'b0}}, irq_en_q};
    end else begin
      err_d   = 1'b1;
    end
  end

  // The answer is registered so every bus output is a flip-flop;
  // the price is one wait state on every access.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc & ~pready;
      if (acc && !pready) begin
        prdata  <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= err_d;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // ***************************************************************
  // Control, interrupt status, clear and enable
  // ***************************************************************
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q     <= `CTRL_RESET;
      irq_stat_q <= {`IRQ_W{1'b0}};
      irq_en_q   <= {`IRQ_W{1'b0}};
      irq        <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata;
      end
      if (wr_en) begin
        irq_en_q <= pwdata[`IRQ_W-1:0];
      end
      // New events win over a clear in the same cycle.
      irq_stat_q <= (irq_stat_q & ~(wr_clr ? pwdata[`IRQ_W-1:0] :
                    {`IRQ_W{1'b0}})) | irq_ev;
      // Registered, so the interrupt trails the status by one cycle.
      irq <= |(irq_stat_q & irq_en_q);
    end
  end

endmodule // tx_input_fault

// ---- hdl/tx_input_fault_defs.vh ----
// Constants for the dual transmit character input and fault flag block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef TX_INPUT_FAULT_DEFS_VH
`define TX_INPUT_FAULT_DEFS_VH

// ***************************************************************
// Register byte offsets on the APB
// ***************************************************************
`define OFS_CTRL       12'h000
`define OFS_STATUS     12'h004
`define OFS_CHAR       12'h008
`define OFS_IRQ_STAT   12'h00C
`define OFS_IRQ_CLR    12'h010
`define OFS_IRQ_EN     12'h014

// ***************************************************************
// Control and status field layout, one byte per channel
// ***************************************************************
`define CH_STRIDE      8
`define CTRL_SEL_BIT   0
`define CTRL_BIST_BIT  1
`define CTRL_DRV1_BIT  2
`define CTRL_DRV2_BIT  3
`define CTRL_HALF_BIT  4
`define CTRL_RCTR_BIT  5
`define CTRL_RESET     32'h0000_2E2E
`define ST_FAULT_BIT   0
`define ST_REF_BIT     1
`define ST_PLL_BIT     2
`define ST_LVL_LSB     4
`define CHAR_B_LSB     16

// ***************************************************************
// Interrupt layout, three event bits per channel
// ***************************************************************
`define IRQ_STRIDE     3
`define IRQ_BUF_BIT    0
`define IRQ_PASS_BIT   1
`define IRQ_LOSS_BIT   2
`define IRQ_W          6

// ***************************************************************
// Timing and sizes
// ***************************************************************
`define CLK_PERIOD_NS  50
`define REF_LOSS_NS    1000
`define REF_LOSS_CYC   (`REF_LOSS_NS / `CLK_PERIOD_NS)
`define BIST_LEN       511
`define CHAR_W         10
`define BUF_DEPTH      8
`define LVL_W          4
`define CNT_W          9

`endif

// ---- hdl/edge_sync.v ----
// Two flip-flop synchroniser for a bus of pins, plus a third stage
// that holds the previous synchronised value for edge finding.
// Assumes every bit arrives from outside the sys_clk domain.
`timescale 1ns/100ps
`include "tx_input_fault_defs.vh"

module edge_sync #(
  parameter WIDTH = 12
) (
  input  wire             sys_clk,   // System clock.
  input  wire             rst_b,     // Asynchronous reset, active low.
  input  wire [WIDTH-1:0] pin_in,    // Asynchronous pins.
  output wire [WIDTH-1:0] sync_out,  // Synchronised value.
  output wire [WIDTH-1:0] prev_out   // Synchronised value, one cycle old.
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;
  reg [WIDTH-1:0] prev_q;

  // The first stage feeds only the second stage.
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign sync_out = sync_q;
  assign prev_out = prev_q;

endmodule // edge_sync

// ---- verif/tx_input_fault_asserts.sv ----
// Checker for the transmit input and fault flag block.
// Assumes it is bound into tx_input_fault and sees only its ports.
`timescale 1ns/100ps
`include "tx_input_fault_defs.vh"

module tx_input_fault_asserts #(
  parameter LOSS_CYC = `REF_LOSS_CYC  // Cycles without ref edge.
) (
  input wire               sys_clk,         // Clock.
  input wire               rst_b,           // Reset, active low.
  input wire               psel,            // APB select.
  input wire               penable,         // APB enable.
  input wire               pready,          // APB ready.
  input wire [31:0]        prdata,          // APB read data.
  input wire               pslverr,         // APB error.
  input wire               ref_clk_in_a,    // Channel A ref clock.
  input wire               tx_fault_flag_a, // Channel A flag.
  input wire               tx_char_vld_a,   // Channel A pulse.
  input wire               tx_char_vld_b,   // Channel B pulse.
  input wire [`CHAR_W-1:0] tx_char_out_a,   // Channel A char.
  input wire [`CHAR_W-1:0] tx_char_out_b    // Channel B char.
);
  // ***************************************************************
  // Properties
  // ***************************************************************
  // The idle count runs on raw pin samples, so a margin covers the
  // synchroniser and the flag register.
  reg [7:0] idle_q;
  reg       ref_prev_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_q     <= 8'h00;
      ref_prev_q <= 1'b0;
    end else begin
      ref_prev_q <= ref_clk_in_a;
      if (ref_clk_in_a != ref_prev_q)
        idle_q <= 8'h00;
      else if (idle_q != 8'hFF)
        idle_q <= idle_q + 8'h01;
    end
  end
  sequence access_start;
    $rose(psel && penable);
  endsequence
  apb_one_wait_a: assert property (access_start |=> pready)
    else $error("ready not one cycle after access");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  read_idle_a: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside ready");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  vld_pulse_a: assert property (tx_char_vld_a |=> !tx_char_vld_a)
    else $error("capture pulse too long");
  out_hold_a: assert property (
    $changed(tx_char_out_a) |-> tx_char_vld_a)
    else $error("channel A char changed without capture");
  out_hold_b_a: assert property (
    $changed(tx_char_out_b) |-> tx_char_vld_b)
    else $error("channel B char changed without capture");
  ref_loss_a: assert property (
    idle_q >= LOSS_CYC + 8 |-> tx_fault_flag_a)
    else $error("flag low with reference absent");
endmodule // tx_input_fault_asserts

bind tx_input_fault tx_input_fault_asserts #(.LOSS_CYC(LOSS_CYC)) u_chk (
  .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .ref_clk_in_a(ref_clk_in_a), .tx_fault_flag_a(tx_fault_flag_a),
  .tx_char_vld_a(tx_char_vld_a), .tx_char_vld_b(tx_char_vld_b),
  .tx_char_out_a(tx_char_out_a), .tx_char_out_b(tx_char_out_b));

// ---- verif/host_video_model.sv ----
// Host side model: character clocks, reference clocks and characters.
// Assumes a 50 ns sys_clk; every clock toggles each fourth cycle.
`timescale 1ns/100ps
`include "tx_input_fault_defs.vh"

module host_video_model (
  input  wire               sys_clk,        // Clock.
  input  wire               rst_b,          // Reset, active low.
  input  wire [1:0]         host_run,       // Host clocks run, B:A.
  input  wire [1:0]         ref_run,        // Ref clocks run, B:A.
  output reg                tx_if_clk_in_a, // Host clock A.
  output reg                tx_if_clk_in_b, // Host clock B.
  output reg                ref_clk_in_a,   // Ref clock A.
  output reg                ref_clk_in_b,   // Ref clock B.
  output reg  [`CHAR_W-1:0] tx_char_in_a,   // Characters A.
  output reg  [`CHAR_W-1:0] tx_char_in_b    // Characters B.
);
  // ***************************************************************
  // Clocks and data
  // ***************************************************************
  // Host clocks toggle two cycles away from the reference clocks, so
  // their phase differs; a stopped clock rests low.
  reg [1:0] ph_q;
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ph_q           <= 2'd0;
      tx_if_clk_in_a <= 1'b0;
      tx_if_clk_in_b <= 1'b0;
      ref_clk_in_a   <= 1'b0;
      ref_clk_in_b   <= 1'b0;
      tx_char_in_a   <= 10'h000;
      tx_char_in_b   <= 10'h155;
    end else begin
      ph_q <= ph_q + 2'd1;
      if (ph_q == 2'd3) begin
        ref_clk_in_a <= ref_run[0] & ~ref_clk_in_a;
        ref_clk_in_b <= ref_run[1] & ~ref_clk_in_b;
      end
      if (ph_q == 2'd1) begin
        tx_if_clk_in_a <= host_run[0] & ~tx_if_clk_in_a;
        tx_if_clk_in_b <= host_run[1] & ~tx_if_clk_in_b;
        // Data moves on the falling edge, stable around the rise.
        if (tx_if_clk_in_a)
          tx_char_in_a <= tx_char_in_a + 10'h025;
        if (tx_if_clk_in_b)
          tx_char_in_b <= tx_char_in_b + 10'h013;
      end
      // Undriven channel A data is not trusted: it toggles every cycle.
      if (!host_run[0])
        tx_char_in_a <= ~tx_char_in_a;
    end
  end
endmodule // host_video_model

// ---- verif/testbench.sv ----
// Self-checking bench for the transmit input and fault flag block.
// Assumes the host model drives the link pins and APB reaches CTRL.
`timescale 1ns/100ps
`include "tx_input_fault_defs.vh"

module testbench;
  // ***************************************************************
  // Bench
  // ***************************************************************
  localparam LOSS = 12;
  reg         sys_clk, rst_b, psel, penable, pwrite, mon_a;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, q;
  reg  [1:0]  host_run, ref_run, hclk_q;
  reg  [9:0]  exp_a, exp_b;
  reg         e;
  wire        pready, pslverr, irq, fa, fb, ca, cb, ra, rb, va, vb;
  wire [31:0] prdata;
  wire [9:0]  da, db, oa, ob;
  integer     failures, num_checks, c, w, t;

  tx_input_fault #(.LOSS_CYC(LOSS)) u_tx_input_fault (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .irq(irq),
    .tx_char_in_a(da), .tx_char_in_b(db), .tx_if_clk_in_a(ca),
    .tx_if_clk_in_b(cb), .ref_clk_in_a(ra), .ref_clk_in_b(rb),
    .tx_fault_flag_a(fa), .tx_fault_flag_b(fb), .tx_char_out_a(oa),
    .tx_char_out_b(ob), .tx_char_vld_a(va), .tx_char_vld_b(vb));
  host_video_model u_host_video_model (
    .sys_clk(sys_clk), .rst_b(rst_b), .host_run(host_run),
    .ref_run(ref_run), .tx_if_clk_in_a(ca), .tx_if_clk_in_b(cb),
    .ref_clk_in_a(ra), .ref_clk_in_b(rb), .tx_char_in_a(da),
    .tx_char_in_b(db));

  task chk(input logic ok, input string m);
    begin
      num_checks++;
      if (ok !== 1'b1) begin
        failures++;
        $display("mismatch at %0t: %s", $time, m);
      end
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    integer n;
    begin
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge sys_clk); n++; end
      while (pready !== 1'b1);
      chk(n == 2, "apb wait state");
      q = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask
  task wait_flag(input logic v, input integer lim);
    integer n;
    begin
      n = 0;
      while (fa !== v && n < lim) begin @(posedge sys_clk); n++; end
      chk(n < lim, "fault flag level");
    end
  endtask
  task count_vld(input integer n);
    begin
      c = 0;
      repeat (n) begin @(posedge sys_clk); if (va === 1'b1) c++; end
    end
  endtask

  // Expected characters are what the pins held at each host rise.
  always @(posedge sys_clk) begin
    hclk_q <= {cb, ca};
    if (ca && !hclk_q[0]) exp_a <= da;
    if (cb && !hclk_q[1]) exp_b <= db;
    if (va === 1'b1 && mon_a) chk(oa === exp_a, "char a");
    if (vb === 1'b1) chk(ob === exp_b, "char b");
  end
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    #2_000_000;
    failures++;
    $display("mismatch at %0t: timeout", $time);
    wrap_up;
  end
  initial begin
    {rst_b, psel, penable, pwrite, paddr, pwdata} = 0;
    failures = 0; num_checks = 0; mon_a = 1'b1; hclk_q = 2'b00;
    host_run = 2'b11; ref_run = 2'b11; exp_a = 0; exp_b = 0;
    cyc(3);
    rst_b <= 1'b1;
    wait_flag(1'b0, 400);
    apb(0, `OFS_CTRL, 0); chk(q === 32'h0000_2E2E, "ctrl reset");
    apb(0, 12'h0FC, 0); chk(e === 1'b1 && q === 0, "unmapped");
    cyc(60);
    mon_a <= 1'b0; host_run[0] <= 1'b0;
    apb(1, `OFS_CTRL, 32'h0000_2E2F); count_vld(160);
    chk(c >= 19 && c <= 21, "ref capture rate");
    apb(1, `OFS_CTRL, 32'h0000_2E3F); count_vld(160);
    chk(c >= 38 && c <= 42, "half rate");
    chk(fa === 1'b0, "flag with ref select");
    apb(1, `OFS_CTRL, 32'h0000_2E2E); host_run[0] <= 1'b1;
    apb(1, `OFS_CTRL, 32'h0000_2E0E); apb(1, `OFS_CTRL, 32'h0000_2E2E);
    wait_flag(1'b0, 200); mon_a <= 1'b1;
    apb(1, `OFS_IRQ_EN, 32'h0000_0005); host_run[0] <= 1'b0;
    wait_flag(1'b1, 200); cyc(3); chk(irq === 1'b1, "irq");
    apb(0, `OFS_IRQ_STAT, 0); chk(q[0] === 1'b1, "buf event");
    apb(1, `OFS_IRQ_EN, 32'h0000_0004); cyc(3);
    chk(irq === 1'b0, "irq mask");
    host_run[0] <= 1'b1; cyc(100);
    chk(fa === 1'b1, "sticky"); chk(fb === 1'b0, "b clean");
    apb(1, `OFS_CTRL, 32'h0000_2E0E); apb(1, `OFS_CTRL, 32'h0000_2E2E);
    wait_flag(1'b0, 200);
    apb(1, `OFS_IRQ_CLR, 32'h0000_0001); apb(0, `OFS_IRQ_STAT, 0);
    chk(q[0] === 1'b0, "irq clear");
    apb(1, `OFS_IRQ_EN, 32'h0000_0005);
    apb(1, `OFS_CTRL, 32'h0000_2E2C); wait_flag(1'b1, 4200);
    w = 0; while (fa === 1'b1 && w < 50) begin cyc(1); w++; end
    t = 0; while (fa !== 1'b1 && t < 4200) begin cyc(1); t++; end
    chk(w >= 7 && w <= 9, "pass pulse width");
    chk(w + t >= 4086 && w + t <= 4090, "pass spacing");
    apb(1, `OFS_CTRL, 32'h0000_2E22); wait_flag(1'b1, 10);
    apb(0, `OFS_STATUS, 0); chk(q[2] === 1'b1, "pll down");
    apb(1, `OFS_CTRL, 32'h0000_2E2E); wait_flag(1'b0, 50);
    ref_run[0] <= 1'b0; wait_flag(1'b1, LOSS + 20);
    apb(0, `OFS_STATUS, 0); chk(q[1] === 1'b0, "ref absent");
    apb(0, `OFS_IRQ_STAT, 0); chk(q[2] === 1'b1, "loss event");
    chk(irq === 1'b1, "loss irq");
    ref_run[0] <= 1'b1; cyc(40);
    apb(1, `OFS_CTRL, 32'h0000_2E0E); apb(1, `OFS_CTRL, 32'h0000_2E2E);
    wait_flag(1'b0, 200);
    apb(1, `OFS_IRQ_CLR, 32'h0000_003F); cyc(3);
    chk(irq === 1'b0, "irq cleared");
    wrap_up;
  end
endmodule // testbench
